// File: common/bth1_map.vh
`ifndef BTH1_MAP_VH
`define BTH1_MAP_VH

// Register indexes; the byte address of each register is four times its index.
`define BTH1_IDX_W             6
`define BTH1_IDX_CLASS_CODE    6'h09
`define BTH1_IDX_CACHE_LINE    6'h0C
`define BTH1_IDX_PRI_LATENCY   6'h0D
`define BTH1_IDX_HEADER_TYPE   6'h0E
`define BTH1_IDX_SELF_TEST     6'h0F
`define BTH1_IDX_BASE_ADDR0    6'h10
`define BTH1_IDX_BASE_ADDR1    6'h14
`define BTH1_IDX_UP_BUS        6'h18
`define BTH1_IDX_DOWN_BUS      6'h19
`define BTH1_IDX_HIGH_BUS      6'h1A
`define BTH1_IDX_SEC_LATENCY   6'h1B
`define BTH1_IDX_IO_LOW        6'h1C
`define BTH1_IDX_IO_HIGH       6'h1D

// Bus geometry.
`define BTH1_ADDR_W            8
`define BTH1_IDX_MSB           7
`define BTH1_IDX_LSB           2

// Fixed field values.
`define BTH1_PROG_IF           8'h00
`define BTH1_SUB_CLASS         8'h04
`define BTH1_BASE_CLASS        8'h06
`define BTH1_HEADER_TYPE       8'h01
`define BTH1_ZERO_BYTE         8'h00
`define BTH1_ZERO_WORD         32'h00000000

// Reset values of writable fields.
`define BTH1_CACHE_LINE_RST    8'h00
`define BTH1_BUS_NUMBER_RST    8'h00
`define BTH1_IO_CAP_RST        1'h1
`define BTH1_IO_BASE_RST       4'hF

// Field positions inside the I/O window registers.
`define BTH1_IO_CAP_BIT        0
`define BTH1_IO_BASE_MSB       7
`define BTH1_IO_BASE_LSB       4
`define BTH1_IO_BASE_W         4
`define BTH1_IO_RSVD_ZERO      3'h0

// AXI responses.
`define BTH1_RESP_OKAY         2'h0
`define BTH1_RESP_SLVERR       2'h2

`endif

// File: logic/bth1_pin_sync.v
`timescale 1ns/1ps
// Three-stage synchroniser; the output follows only when stages two and three agree.
module bth1_pin_sync (
   input  wire ref_clk,
   input  wire rst,
   input  wire pinIn,
   output reg  pinSync
);
   reg stageOne;
   reg stageTwo;
   reg stageThree;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stageOne   <= 1'h0;
         stageTwo   <= 1'h0;
         stageThree <= 1'h0;
         pinSync    <= 1'h0;
      end else begin
         stageOne   <= pinIn;
         stageTwo   <= stageOne;
         stageThree <= stageTwo;
         if (stageTwo == stageThree) begin
            pinSync <= stageThree;
         end
      end
   end
endmodule // bth1_pin_sync

// File: logic/bth1_field_reg.v
`timescale 1ns/1ps
// Writable field with a constant reset value.
module bth1_field_reg #(
   parameter WIDTH     = 8,
   parameter RESET_VAL = 0
) (
   input  wire             ref_clk,
   input  wire             rst,
   input  wire             wrEn,
   input  wire [WIDTH-1:0] wrData,
   output reg  [WIDTH-1:0] q
);
   localparam [WIDTH-1:0] RESET_BITS = RESET_VAL;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= RESET_BITS;
      end else if (wrEn) begin
         q <= wrData;
      end
   end
endmodule // bth1_field_reg

// File: logic/bth1_header_regs.v
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "bth1_map.vh"

module bth1_header_regs (
   input  wire                    ref_clk,
   input  wire                    rst,
   input  wire                    capLockPin,
   input  wire [`BTH1_ADDR_W-1:0] s_axi_awaddr,
   input  wire                    s_axi_awvalid,
   output reg                     s_axi_awready,
   input  wire [31:0]             s_axi_wdata,
   input  wire [3:0]              s_axi_wstrb,
   input  wire                    s_axi_wvalid,
   output reg                     s_axi_wready,
   output reg  [1:0]              s_axi_bresp,
   output reg                     s_axi_bvalid,
   input  wire                    s_axi_bready,
   input  wire [`BTH1_ADDR_W-1:0] s_axi_araddr,
   input  wire                    s_axi_arvalid,
   output reg                     s_axi_arready,
   output reg  [31:0]             s_axi_rdata,
   output reg  [1:0]              s_axi_rresp,
   output reg                     s_axi_rvalid,
   input  wire                    s_axi_rready,
   output wire [7:0]              downstreamBusNumber,
   output wire [7:0]              highestBusBehind,
   output wire [3:0]              ioWindowBaseHigh,
   output wire                    ioWidthCapability
);

   // Write channel capture.
   reg  [`BTH1_ADDR_W-1:0] wrAddr;
   // Only the low byte and its strobe are kept, since no writable field here reaches above bit 7.
   reg  [7:0]              wrByte;
   reg                     wrLaneOn;
   reg                     awHeld;
   reg                     wHeld;
   reg                     next_awHeld;
   reg                     next_wHeld;
   reg                     next_bvalid;
   reg                     next_rvalid;
   wire                    awFire;
   wire                    wFire;
   wire                    arFire;
   wire                    wrFire;
   wire [`BTH1_IDX_W-1:0]  wrIdx;
   wire [`BTH1_IDX_W-1:0]  rdIdx;

   // Register contents.
   wire [7:0]              cacheLineSize;
   wire [7:0]              upstreamBusNumber;
   wire                    capLocked;

   // Decode results.
   reg                     wrMapped;
   reg                     rdMapped;
   reg  [31:0]             rdWord;
   wire                    wrByteOk;

   assign awFire = s_axi_awvalid && s_axi_awready;
   assign wFire  = s_axi_wvalid && s_axi_wready;
   assign arFire = s_axi_arvalid && s_axi_arready;
   // A write commits only once both halves are held and the last response has gone.
   assign wrFire = awHeld && wHeld && !s_axi_bvalid;
   assign wrIdx  = wrAddr[`BTH1_IDX_MSB:`BTH1_IDX_LSB];
   assign rdIdx  = s_axi_araddr[`BTH1_IDX_MSB:`BTH1_IDX_LSB];
   assign wrByteOk = wrFire && wrLaneOn;

   // The lock pin comes from outside the clock domain, so it is filtered before use.
   // A glitch shorter than one clock period never reaches the capability store.
   bth1_pin_sync u_lock_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pinIn   (capLockPin),
      .pinSync (capLocked)
   );

   // Channel state: address and data may arrive in either order or together.
   always @* begin
      next_awHeld = awHeld;
      next_wHeld  = wHeld;
      if (wrFire) begin
         next_awHeld = 1'h0;
         next_wHeld  = 1'h0;
      end else begin
         if (awFire) begin
            next_awHeld = 1'h1;
         end
         if (wFire) begin
            next_wHeld = 1'h1;
         end
      end
      next_bvalid = wrFire || (s_axi_bvalid && !s_axi_bready);
      next_rvalid = arFire || (s_axi_rvalid && !s_axi_rready);
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         awHeld        <= 1'h0;
         wHeld         <= 1'h0;
         wrAddr        <= {`BTH1_ADDR_W{1'b0}};
         wrByte        <= `BTH1_ZERO_BYTE;
         wrLaneOn      <= 1'h0;
         s_axi_awready <= 1'h0;
         s_axi_wready  <= 1'h0;
         s_axi_bvalid  <= 1'h0;
         s_axi_bresp   <= `BTH1_RESP_OKAY;
      end else begin
         awHeld        <= next_awHeld;
         wHeld         <= next_wHeld;
         // Ready drops while a half is held or a response waits, so no beat is lost.
         s_axi_awready <= !next_awHeld && !next_bvalid;
         s_axi_wready  <= !next_wHeld && !next_bvalid;
         s_axi_bvalid  <= next_bvalid;
         if (awFire) begin
            wrAddr <= s_axi_awaddr;
         end
         if (wFire) begin
            wrByte   <= s_axi_wdata[7:0];
            wrLaneOn <= s_axi_wstrb[0];
         end
         if (wrFire) begin
            s_axi_bresp <= wrMapped ? `BTH1_RESP_OKAY : `BTH1_RESP_SLVERR;
         end
      end
   end

   // Every writable register is one byte or narrower at the bottom of its word, so only lane 0 writes.
   // A write to a read-only index still answers OKAY and changes nothing.
   always @* begin
      case (wrIdx)
         `BTH1_IDX_CLASS_CODE,
         `BTH1_IDX_CACHE_LINE,
         `BTH1_IDX_PRI_LATENCY,
         `BTH1_IDX_HEADER_TYPE,
         `BTH1_IDX_SELF_TEST,
         `BTH1_IDX_BASE_ADDR0,
         `BTH1_IDX_BASE_ADDR1,
         `BTH1_IDX_UP_BUS,
         `BTH1_IDX_DOWN_BUS,
         `BTH1_IDX_HIGH_BUS,
         `BTH1_IDX_SEC_LATENCY,
         `BTH1_IDX_IO_LOW,
         `BTH1_IDX_IO_HIGH: begin
            wrMapped = 1'h1;
         end
         default: begin
            wrMapped = 1'h0;
         end
      endcase
   end

   bth1_field_reg #(.WIDTH(8), .RESET_VAL(`BTH1_CACHE_LINE_RST)) u_cache_line (
      .ref_clk (ref_clk),
      .rst     (rst),
      .wrEn    (wrByteOk && (wrIdx == `BTH1_IDX_CACHE_LINE)),
      .wrData  (wrByte),
      .q       (cacheLineSize)
   );

   // The bus numbers are stored for software, and the downstream and highest ones also drive output ports; nothing inside this block acts on them.
   bth1_field_reg #(.WIDTH(8), .RESET_VAL(`BTH1_BUS_NUMBER_RST)) u_up_bus (
      .ref_clk (ref_clk),
      .rst     (rst),
      .wrEn    (wrByteOk && (wrIdx == `BTH1_IDX_UP_BUS)),
      .wrData  (wrByte),
      .q       (upstreamBusNumber)
   );

   bth1_field_reg #(.WIDTH(8), .RESET_VAL(`BTH1_BUS_NUMBER_RST)) u_down_bus (
      .ref_clk (ref_clk),
      .rst     (rst),
      .wrEn    (wrByteOk && (wrIdx == `BTH1_IDX_DOWN_BUS)),
      .wrData  (wrByte),
      .q       (downstreamBusNumber)
   );

   bth1_field_reg #(.WIDTH(8), .RESET_VAL(`BTH1_BUS_NUMBER_RST)) u_high_bus (
      .ref_clk (ref_clk),
      .rst     (rst),
      .wrEn    (wrByteOk && (wrIdx == `BTH1_IDX_HIGH_BUS)),
      .wrData  (wrByte),
      .q       (highestBusBehind)
   );

   // The capability bit is frozen while the lock pin holds it; the base field stays writable.
   bth1_field_reg #(.WIDTH(1), .RESET_VAL(`BTH1_IO_CAP_RST)) u_io_cap (
      .ref_clk (ref_clk),
      .rst     (rst),
      .wrEn    (wrByteOk && (wrIdx == `BTH1_IDX_IO_LOW) && !capLocked),
      .wrData  (wrByte[`BTH1_IO_CAP_BIT]),
      .q       (ioWidthCapability)
   );

   bth1_field_reg #(.WIDTH(`BTH1_IO_BASE_W), .RESET_VAL(`BTH1_IO_BASE_RST)) u_io_base (
      .ref_clk (ref_clk),
      .rst     (rst),
      .wrEn    (wrByteOk && (wrIdx == `BTH1_IDX_IO_LOW)),
      .wrData  (wrByte[`BTH1_IO_BASE_MSB:`BTH1_IO_BASE_LSB]),
      .q       (ioWindowBaseHigh)
   );

   // Writes to the limit index land on no store; only its mirror bit is read back.

   // Read decode; writes to the constant registers reach none of the stores above.
   // Unmapped indexes answer with an error response and zero data, so a stray
   // access is visible to software instead of silently reading as a blank register.
   always @* begin
      rdMapped = 1'h1;
      rdWord   = `BTH1_ZERO_WORD;
      case (rdIdx)
         `BTH1_IDX_CLASS_CODE: begin
            rdWord[7:0]   = `BTH1_PROG_IF;
            rdWord[15:8]  = `BTH1_SUB_CLASS;
            rdWord[23:16] = `BTH1_BASE_CLASS;
         end
         `BTH1_IDX_CACHE_LINE: begin
            rdWord[7:0] = cacheLineSize;
         end
         `BTH1_IDX_PRI_LATENCY: begin
            rdWord[7:0] = `BTH1_ZERO_BYTE;
         end
         `BTH1_IDX_HEADER_TYPE: begin
            rdWord[7:0] = `BTH1_HEADER_TYPE;
         end
         `BTH1_IDX_SELF_TEST: begin
            rdWord[7:0] = `BTH1_ZERO_BYTE;
         end
         `BTH1_IDX_BASE_ADDR0,
         `BTH1_IDX_BASE_ADDR1: begin
            rdWord = `BTH1_ZERO_WORD;
         end
         `BTH1_IDX_UP_BUS: begin
            rdWord[7:0] = upstreamBusNumber;
         end
         `BTH1_IDX_DOWN_BUS: begin
            rdWord[7:0] = downstreamBusNumber;
         end
         `BTH1_IDX_HIGH_BUS: begin
            rdWord[7:0] = highestBusBehind;
         end
         `BTH1_IDX_SEC_LATENCY: begin
            rdWord[7:0] = `BTH1_ZERO_BYTE;
         end
         `BTH1_IDX_IO_LOW: begin
            rdWord[`BTH1_IO_CAP_BIT] = ioWidthCapability;
            rdWord[3:1] = `BTH1_IO_RSVD_ZERO;
            rdWord[`BTH1_IO_BASE_MSB:`BTH1_IO_BASE_LSB] = ioWindowBaseHigh;
         end
         `BTH1_IDX_IO_HIGH: begin
            // Only the mirrored capability bit lives here; the limit field belongs elsewhere.
            rdWord[`BTH1_IO_CAP_BIT] = ioWidthCapability;
         end
         default: begin
            rdMapped = 1'h0;
         end
      endcase
   end

   // One read is held at a time: arready stays low while a response waits,
   // which trades throughput for a single capture register.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'h0;
         s_axi_rvalid  <= 1'h0;
         s_axi_rdata   <= `BTH1_ZERO_WORD;
         s_axi_rresp   <= `BTH1_RESP_OKAY;
      end else begin
         s_axi_arready <= !next_rvalid;
         s_axi_rvalid  <= next_rvalid;
         if (arFire) begin
            s_axi_rdata <= rdWord;
            s_axi_rresp <= rdMapped ? `BTH1_RESP_OKAY : `BTH1_RESP_SLVERR;
         end
      end
   end

endmodule // bth1_header_regs

// File: dv/bth1_header_regs_monitor.sv
`timescale 1ns/1ps
module bth1_header_regs_monitor (
   input wire        ref_clk,
   input wire        rst,
   input wire        capLockPin,
   input wire [7:0]  s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0]  s_axi_wstrb,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire [7:0]  s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [7:0]  downstreamBusNumber,
   input wire [7:0]  highestBusBehind,
   input wire [3:0]  ioWindowBaseHigh,
   input wire        ioWidthCapability
);
   // The byte is kept because the master may change its data once the word is taken.
   logic [7:0] wrByte;
   always @(posedge ref_clk) begin
      if (s_axi_wvalid && s_axi_wready) wrByte <= s_axi_wdata[7:0];
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence wr_take(a);
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0] && s_axi_awaddr == a;
   endsequence
   sequence rd_take(a);
      s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
   endsequence
   sequence committed;
      ##1 s_axi_bvalid && s_axi_bresp == 2'h0;
   endsequence
   chk_class_code: assert property (rd_take(8'h24) |=> s_axi_rdata == 32'h00060400)
      else $error("class code wrong");
   chk_fixed_zero: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr inside {8'h34, 8'h3C, 8'h40, 8'h50, 8'h6C} |=> s_axi_rdata == 32'h0) else $error("fixed zero read");
   chk_io_low: assert property (rd_take(8'h70) |=>
      s_axi_rdata == {24'h0, ioWindowBaseHigh, 3'h0, ioWidthCapability}) else $error("io window low wrong");
   chk_io_mirror: assert property (rd_take(8'h74) |=> s_axi_rdata == {31'h0, ioWidthCapability})
      else $error("io mirror wrong");
   chk_down_write: assert property (wr_take(8'h64) |=> committed ##0 downstreamBusNumber == wrByte)
      else $error("downstream bus write lost");
   chk_base_write: assert property (wr_take(8'h70) |=> committed ##0 ioWindowBaseHigh == wrByte[7:4])
      else $error("io base write lost");
   chk_reset_vals: assert property ($fell(rst) |-> downstreamBusNumber == 8'h00 &&
      highestBusBehind == 8'h00 && ioWindowBaseHigh == 4'hF && ioWidthCapability) else $error("reset values wrong");
   chk_cap_locked: assert property (capLockPin [*6] |=> $stable(ioWidthCapability))
      else $error("locked capability moved");
endmodule // bth1_header_regs_monitor

bind bth1_header_regs bth1_header_regs_monitor u_mon (.*);

// File: dv/bth1_header_regs_tb.sv
`timescale 1ns/1ps
module bth1_header_regs_tb;
   logic        ref_clk, rst, capLockPin;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, downstreamBusNumber, highestBusBehind;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, ioWindowBaseHigh;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ioWidthCapability;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          mismatches, n_compared, cycles;
   logic [7:0]  addrs [13] = '{8'h24, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h50, 8'h60, 8'h64, 8'h68, 8'h6C, 8'h70, 8'h74};

   bth1_header_regs u_dut (.*);

   initial begin
      ref_clk = 1'h0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic end_sim;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // About 90 transfers of under ten cycles each fit well inside this ceiling.
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         mismatches++;
         end_sim;
      end
   end

   task automatic chk_data(input string what, input logic [31:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic chk_resp(input string what, input logic [1:0] exp, got);
      chk_data(what, {30'h0, exp}, {30'h0, got});
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      bit aw, w;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!(aw && w)) begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'h0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'h0;
         end
      end
      do @(posedge ref_clk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge ref_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge ref_clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask

   task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic [1:0] r;
      axi_write(a, d, s, r);
      chk_resp("write response", er, r);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(a, d, r);
      chk_data("read data", exp, d);
      chk_resp("read response", er, r);
   endtask

   function automatic logic [31:0] exp_val(input logic [7:0] a, rw, io);
      case (a)
         8'h24: exp_val = 32'h00060400;
         8'h38: exp_val = 32'h00000001;
         8'h30, 8'h60, 8'h64, 8'h68: exp_val = {24'h0, rw};
         8'h70: exp_val = {24'h0, io[7:4], 3'h0, io[0]};
         8'h74: exp_val = {31'h0, io[0]};
         default: exp_val = 32'h0;
      endcase
   endfunction

   task automatic sweep(input logic [7:0] rw, io, input logic [31:0] ports);
      for (int i = 0; i < 13; i++) rd_chk(addrs[i], exp_val(addrs[i], rw, io), 2'h0);
      chk_data("port outputs", ports, {11'h0, downstreamBusNumber, highestBusBehind, ioWindowBaseHigh, ioWidthCapability});
   endtask

   initial begin
      rst = 1'h1;
      capLockPin = 1'h0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      s_axi_awvalid = 1'h0;
      s_axi_wvalid = 1'h0;
      s_axi_bready = 1'h0;
      s_axi_arvalid = 1'h0;
      s_axi_rready = 1'h0;
      repeat (10) @(posedge ref_clk);
      rst <= 1'h0;
      sweep(8'h00, 8'hF1, {11'h0, 8'h00, 8'h00, 4'hF, 1'h1});
      $display("test reset values done");
      for (int i = 0; i < 13; i++) wr_chk(addrs[i], 32'h5A5A5AA5, 4'hF, 2'h0);
      sweep(8'hA5, 8'hA5, {11'h0, 8'hA5, 8'hA5, 4'hA, 1'h1});
      for (int i = 0; i < 13; i++) wr_chk(addrs[i], 32'h0, 4'hF, 2'h0);
      sweep(8'h00, 8'h00, 32'h0);
      $display("test write all done");
      wr_chk(8'h64, 32'h33, 4'hE, 2'h0);
      rd_chk(8'h64, 32'h0, 2'h0);
      wr_chk(8'h44, 32'h33, 4'hF, 2'h2);
      rd_chk(8'h44, 32'h0, 2'h2);
      $display("test strobe and unmapped done");
      capLockPin <= 1'h1;
      repeat (8) @(posedge ref_clk);
      wr_chk(8'h70, 32'hB1, 4'h1, 2'h0);
      rd_chk(8'h70, 32'hB0, 2'h0);
      rd_chk(8'h74, 32'h0, 2'h0);
      capLockPin <= 1'h0;
      repeat (8) @(posedge ref_clk);
      wr_chk(8'h70, 32'hB1, 4'h1, 2'h0);
      rd_chk(8'h70, 32'hB1, 2'h0);
      rd_chk(8'h74, 32'h1, 2'h0);
      $display("test capability lock done");
      wr_chk(8'h64, 32'h5C, 4'h1, 2'h0);
      rst <= 1'h1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'h0;
      sweep(8'h00, 8'hF1, {11'h0, 8'h00, 8'h00, 4'hF, 1'h1});
      $display("test second reset done");
      end_sim;
   end
endmodule // bth1_header_regs_tb
